// [hw/gcm_mem.sv]
module gcm_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write port
   input wire logic we_i,
   input wire logic and_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // Read port
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem_reg [2**AW];

   // Flash program ANDs into the cell, RAM overwrites
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 2**AW; i++) begin
            mem_reg[i] <= gcm_pkg::FLASH_BLANK;
         end
      end else if (we_i) begin
         mem_reg[waddr_i] <= and_i ? (mem_reg[waddr_i] & wdata_i) : wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem_reg[raddr_i];
      end
   end

endmodule

// [hw/gcm_pair.sv]
module gcm_pair #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic clr_i,
   input wire logic inc_i,
   // Count
   output logic [W-1:0] count_o,
   output logic wrap_o
);

   // Free-running pair, wraps past all ones
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= '0;
      end else if (clr_i) begin
         count_o <= '0;
      end else if (inc_i) begin
         count_o <= count_o + 1'b1;
      end
   end

   assign wrap_o = inc_i && !clr_i && (&count_o);

endmodule

// [hw/gcm_pkg.sv]
package gcm_pkg;

   // Address map
   localparam logic [15:0] ADDR_TOP = 16'h011f;
   localparam logic [15:0] ADDR_ALIAS_BASE = 16'h0120;
   localparam logic [7:0] ADDR_ALIAS_LOW = 8'h20;
   localparam logic [15:0] ADDR_FLASH_END = 16'h00df;
   localparam logic [15:0] ADDR_RAM_END = 16'h00ff;
   localparam logic [15:0] ADDR_RESERVED = 16'h0100;
   localparam logic [15:0] ADDR_PAGE_LOCK = 16'h0101;
   localparam logic [15:0] ADDR_TEMP_LOW = 16'h0102;
   localparam logic [15:0] ADDR_TEMP_HIGH = 16'h0103;
   localparam logic [15:0] ADDR_CLEAR_CTRL = 16'h0104;
   localparam logic [15:0] ADDR_SLEEP_WAKE = 16'h0105;
   localparam logic [15:0] ADDR_CHG_TIMER_LOW = 16'h0106;
   localparam logic [15:0] ADDR_CHG_TIMER_HIGH = 16'h0107;
   localparam logic [15:0] ADDR_DIS_TIMER_LOW = 16'h0108;
   localparam logic [15:0] ADDR_DIS_TIMER_HIGH = 16'h0109;
   localparam logic [15:0] ADDR_SELF_DIS_LOW = 16'h010a;
   localparam logic [15:0] ADDR_SELF_DIS_HIGH = 16'h010b;
   localparam logic [15:0] ADDR_CHG_COUNT_LOW = 16'h010c;
   localparam logic [15:0] ADDR_CHG_COUNT_HIGH = 16'h010d;
   localparam logic [15:0] ADDR_DIS_COUNT_LOW = 16'h010e;
   localparam logic [15:0] ADDR_DIS_COUNT_HIGH = 16'h010f;
   localparam int PAGE_BITS = 5;

   // Clear control bits
   localparam int CLR_DIS_COUNT = 0;
   localparam int CLR_CHG_COUNT = 1;
   localparam int CLR_SELF_DIS = 2;
   localparam int CLR_DIS_TIME = 3;
   localparam int CLR_CHG_TIME = 4;
   localparam int CLR_STAT_LEVEL = 5;
   localparam int CLR_POWER_LOSS = 6;
   localparam logic [7:0] CLR_RESET = 8'h60;
   localparam logic [7:0] CLR_CMD_MASK = 8'h1f;

   // Sleep and wake bits
   localparam int SW_WOE_LSB = 1;
   localparam int SW_SLOW_DIS = 4;
   localparam int SW_SLOW_CHG = 5;
   localparam int SW_SLEEP_ALLOW = 6;
   localparam logic [7:0] SW_RESET = 8'h4e;
   localparam logic [7:0] SW_HOST_MASK = 8'h4e;

   // Flash state after reset
   localparam logic [7:0] FLASH_BLANK = 8'hff;
   localparam logic [7:0] LOCK_RESET = 8'hff;

   // Timer rates
   localparam longint unsigned CLK_PERIOD_PS = 64'd10000;
   localparam longint unsigned FAST_PERIOD_US = 64'd878900;
   localparam longint unsigned SLOW_PERIOD_S = 64'd225;
   localparam longint unsigned FAST_CYCLES = FAST_PERIOD_US * 64'd1000000 / CLK_PERIOD_PS;
   localparam longint unsigned SLOW_CYCLES = SLOW_PERIOD_S * 64'd1000000000000 / CLK_PERIOD_PS;
   localparam int PRESCALE_W = 36;

   typedef enum logic [1:0] {
      GCM_RD_REG,
      GCM_RD_MEM,
      GCM_RD_ZERO
   } gcm_rd_src_t;

endpackage

// [hw/gcm_regs.sv]
module gcm_regs #(
   parameter longint unsigned FAST_CYCLES = gcm_pkg::FAST_CYCLES,
   parameter longint unsigned SLOW_CYCLES = gcm_pkg::SLOW_CYCLES,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Host memory command port
   input wire logic [15:0] mem_addr_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic mem_rd_i,
   output logic [7:0] mem_rdata_o,
   output logic mem_rvalid_o,
   // Converter and sensor events
   input wire logic vfc_pulse_i,
   input wire logic sense_discharge_i,
   input wire logic sense_charge_i,
   input wire logic self_dis_tick_i,
   input wire logic [15:0] die_temperature_i,
   // Pins and configuration
   output logic stat_o,
   output logic stat_oe_o,
   output logic sleep_allow_o,
   output logic [2:0] wake_threshold_o
);

   logic rst_meta_reg;
   logic rst_n;
   logic [15:0] eff_addr;
   logic wr_mem;
   logic wr_and;
   logic page_locked;
   logic [7:0] clr_reg;
   logic [7:0] sw_reg;
   logic [7:0] lock_reg;
   logic [15:0] temp_reg;
   logic [CNT_W-1:0] dis_count;
   logic [CNT_W-1:0] chg_count;
   logic [CNT_W-1:0] self_count;
   logic [CNT_W-1:0] dis_time;
   logic [CNT_W-1:0] chg_time;
   logic dis_time_wrap;
   logic chg_time_wrap;
   logic [gcm_pkg::PRESCALE_W-1:0] dis_pre_reg;
   logic [gcm_pkg::PRESCALE_W-1:0] chg_pre_reg;
   logic [gcm_pkg::PRESCALE_W-1:0] dis_lim;
   logic [gcm_pkg::PRESCALE_W-1:0] chg_lim;
   logic dis_tick;
   logic chg_tick;
   logic [7:0] mem_q;
   logic [7:0] reg_val;
   logic [7:0] reg_val_reg;
   gcm_pkg::gcm_rd_src_t src;
   gcm_pkg::gcm_rd_src_t src_reg;
   logic rd_reg;

   localparam logic [gcm_pkg::PRESCALE_W-1:0] FAST_LIM =
      gcm_pkg::PRESCALE_W'(FAST_CYCLES - 64'd1);
   localparam logic [gcm_pkg::PRESCALE_W-1:0] SLOW_LIM =
      gcm_pkg::PRESCALE_W'(SLOW_CYCLES - 64'd1);

   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Address folding above the decoded space
   always_comb begin
      if (mem_addr_i <= gcm_pkg::ADDR_TOP) begin
         eff_addr = mem_addr_i;
      end else if (mem_addr_i[7:0] >= gcm_pkg::ADDR_ALIAS_LOW) begin
         eff_addr = {8'h00, mem_addr_i[7:0]};
      end else begin
         eff_addr = {8'h01, mem_addr_i[7:0]};
      end
   end

   // Flash pages program by AND and honour lock bits, page 7 is RAM
   always_comb begin
      page_locked = !lock_reg[eff_addr[7:gcm_pkg::PAGE_BITS]];
      wr_and = (eff_addr <= gcm_pkg::ADDR_FLASH_END);
      wr_mem = mem_wr_i && (eff_addr <= gcm_pkg::ADDR_RAM_END) && !(wr_and && page_locked);
   end

   gcm_mem #(
      .AW(8),
      .DW(8)
   ) u_mem (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .we_i(wr_mem),
      .and_i(wr_and),
      .waddr_i(eff_addr[7:0]),
      .wdata_i(mem_wdata_i),
      .raddr_i(eff_addr[7:0]),
      .rdata_o(mem_q)
   );

   // Lock bits are a flash byte: programming only clears bits
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= gcm_pkg::LOCK_RESET;
      end else if (mem_wr_i && eff_addr == gcm_pkg::ADDR_PAGE_LOCK) begin
         lock_reg <= lock_reg & mem_wdata_i;
      end
   end

   // Die temperature snapshot
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         temp_reg <= '0;
      end else begin
         temp_reg <= die_temperature_i;
      end
   end

   // Clear control: host write sets, completed clear drops the bit
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         clr_reg <= gcm_pkg::CLR_RESET;
      end else if (mem_wr_i && eff_addr == gcm_pkg::ADDR_CLEAR_CTRL) begin
         clr_reg[gcm_pkg::CLR_DIS_COUNT] <= mem_wdata_i[gcm_pkg::CLR_DIS_COUNT];
         clr_reg[gcm_pkg::CLR_CHG_COUNT] <= mem_wdata_i[gcm_pkg::CLR_CHG_COUNT];
         clr_reg[gcm_pkg::CLR_SELF_DIS] <= mem_wdata_i[gcm_pkg::CLR_SELF_DIS];
         clr_reg[gcm_pkg::CLR_DIS_TIME] <= mem_wdata_i[gcm_pkg::CLR_DIS_TIME];
         clr_reg[gcm_pkg::CLR_CHG_TIME] <= mem_wdata_i[gcm_pkg::CLR_CHG_TIME];
         clr_reg[gcm_pkg::CLR_STAT_LEVEL] <= mem_wdata_i[gcm_pkg::CLR_STAT_LEVEL];
         clr_reg[gcm_pkg::CLR_POWER_LOSS] <= clr_reg[gcm_pkg::CLR_POWER_LOSS] &
                                            mem_wdata_i[gcm_pkg::CLR_POWER_LOSS];
         clr_reg[7] <= 1'b0;
      end else begin
         clr_reg <= clr_reg & ~gcm_pkg::CLR_CMD_MASK;
      end
   end

   // Open-drain status pin: zero drives low
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         stat_o <= 1'b0;
         stat_oe_o <= 1'b0;
      end else begin
         stat_o <= 1'b0;
         stat_oe_o <= !clr_reg[gcm_pkg::CLR_STAT_LEVEL];
      end
   end

   // Counter pairs
   gcm_pair #(.W(CNT_W)) u_dis_count (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(clr_reg[gcm_pkg::CLR_DIS_COUNT]),
      .inc_i(vfc_pulse_i && sense_discharge_i),
      .count_o(dis_count),
      .wrap_o()
   );

   gcm_pair #(.W(CNT_W)) u_chg_count (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(clr_reg[gcm_pkg::CLR_CHG_COUNT]),
      .inc_i(vfc_pulse_i && sense_charge_i),
      .count_o(chg_count),
      .wrap_o()
   );

   gcm_pair #(.W(CNT_W)) u_self_count (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(clr_reg[gcm_pkg::CLR_SELF_DIS]),
      .inc_i(self_dis_tick_i),
      .count_o(self_count),
      .wrap_o()
   );

   gcm_pair #(.W(CNT_W)) u_dis_time (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(clr_reg[gcm_pkg::CLR_DIS_TIME]),
      .inc_i(dis_tick),
      .count_o(dis_time),
      .wrap_o(dis_time_wrap)
   );

   gcm_pair #(.W(CNT_W)) u_chg_time (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(clr_reg[gcm_pkg::CLR_CHG_TIME]),
      .inc_i(chg_tick),
      .count_o(chg_time),
      .wrap_o(chg_time_wrap)
   );

   // Time base rate follows the slow flag
   always_comb begin
      dis_lim = sw_reg[gcm_pkg::SW_SLOW_DIS] ? SLOW_LIM : FAST_LIM;
      chg_lim = sw_reg[gcm_pkg::SW_SLOW_CHG] ? SLOW_LIM : FAST_LIM;
      dis_tick = sense_discharge_i && (dis_pre_reg >= dis_lim);
      chg_tick = sense_charge_i && (chg_pre_reg >= chg_lim);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dis_pre_reg <= '0;
      end else if (clr_reg[gcm_pkg::CLR_DIS_TIME] || dis_tick) begin
         dis_pre_reg <= '0;
      end else if (sense_discharge_i) begin
         dis_pre_reg <= dis_pre_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chg_pre_reg <= '0;
      end else if (clr_reg[gcm_pkg::CLR_CHG_TIME] || chg_tick) begin
         chg_pre_reg <= '0;
      end else if (sense_charge_i) begin
         chg_pre_reg <= chg_pre_reg + 1'b1;
      end
   end

   // Sleep and wake configuration with slow-rate flags
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sw_reg <= gcm_pkg::SW_RESET;
      end else begin
         if (mem_wr_i && eff_addr == gcm_pkg::ADDR_SLEEP_WAKE) begin
            sw_reg[gcm_pkg::SW_SLEEP_ALLOW] <= mem_wdata_i[gcm_pkg::SW_SLEEP_ALLOW];
            sw_reg[gcm_pkg::SW_WOE_LSB +: 3] <= mem_wdata_i[gcm_pkg::SW_WOE_LSB +: 3];
         end
         if (clr_reg[gcm_pkg::CLR_DIS_TIME]) begin
            sw_reg[gcm_pkg::SW_SLOW_DIS] <= 1'b0;
         end else if (dis_time_wrap) begin
            sw_reg[gcm_pkg::SW_SLOW_DIS] <= !sw_reg[gcm_pkg::SW_SLOW_DIS];
         end
         if (clr_reg[gcm_pkg::CLR_CHG_TIME]) begin
            sw_reg[gcm_pkg::SW_SLOW_CHG] <= 1'b0;
         end else if (chg_time_wrap) begin
            sw_reg[gcm_pkg::SW_SLOW_CHG] <= !sw_reg[gcm_pkg::SW_SLOW_CHG];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sleep_allow_o <= gcm_pkg::SW_RESET[gcm_pkg::SW_SLEEP_ALLOW];
         wake_threshold_o <= gcm_pkg::SW_RESET[gcm_pkg::SW_WOE_LSB +: 3];
      end else begin
         sleep_allow_o <= sw_reg[gcm_pkg::SW_SLEEP_ALLOW];
         wake_threshold_o <= sw_reg[gcm_pkg::SW_WOE_LSB +: 3];
      end
   end

   // Read source decode
   always_comb begin
      src = gcm_pkg::GCM_RD_REG;
      reg_val = 8'h00;
      if (eff_addr <= gcm_pkg::ADDR_RAM_END) begin
         src = gcm_pkg::GCM_RD_MEM;
      end else if (eff_addr == gcm_pkg::ADDR_RESERVED) begin
         src = gcm_pkg::GCM_RD_ZERO;
      end else if (eff_addr == gcm_pkg::ADDR_PAGE_LOCK) begin
         reg_val = lock_reg;
      end else if (eff_addr == gcm_pkg::ADDR_TEMP_LOW) begin
         reg_val = temp_reg[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_TEMP_HIGH) begin
         reg_val = temp_reg[15:8];
      end else if (eff_addr == gcm_pkg::ADDR_CLEAR_CTRL) begin
         reg_val = clr_reg;
      end else if (eff_addr == gcm_pkg::ADDR_SLEEP_WAKE) begin
         reg_val = sw_reg;
      end else if (eff_addr == gcm_pkg::ADDR_CHG_TIMER_LOW) begin
         reg_val = chg_time[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_CHG_TIMER_HIGH) begin
         reg_val = chg_time[15:8];
      end else if (eff_addr == gcm_pkg::ADDR_DIS_TIMER_LOW) begin
         reg_val = dis_time[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_DIS_TIMER_HIGH) begin
         reg_val = dis_time[15:8];
      end else if (eff_addr == gcm_pkg::ADDR_SELF_DIS_LOW) begin
         reg_val = self_count[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_SELF_DIS_HIGH) begin
         reg_val = self_count[15:8];
      end else if (eff_addr == gcm_pkg::ADDR_CHG_COUNT_LOW) begin
         reg_val = chg_count[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_CHG_COUNT_HIGH) begin
         reg_val = chg_count[15:8];
      end else if (eff_addr == gcm_pkg::ADDR_DIS_COUNT_LOW) begin
         reg_val = dis_count[7:0];
      end else if (eff_addr == gcm_pkg::ADDR_DIS_COUNT_HIGH) begin
         reg_val = dis_count[15:8];
      end else begin
         src = gcm_pkg::GCM_RD_ZERO;
      end
   end

   // Read pipeline: request, fetch, answer
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= 1'b0;
         src_reg <= gcm_pkg::GCM_RD_ZERO;
         reg_val_reg <= 8'h00;
      end else begin
         rd_reg <= mem_rd_i;
         src_reg <= src;
         reg_val_reg <= reg_val;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata_o <= 8'h00;
         mem_rvalid_o <= 1'b0;
      end else begin
         mem_rvalid_o <= rd_reg;
         case (src_reg)
            gcm_pkg::GCM_RD_MEM: mem_rdata_o <= mem_q;
            gcm_pkg::GCM_RD_REG: mem_rdata_o <= reg_val_reg;
            default: mem_rdata_o <= 8'h00;
         endcase
      end
   end

endmodule

// [tb/gauge_counter_register_map_tb_top.sv]
module gauge_counter_register_map_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk_i;
   logic rstn_i;
   logic [15:0] mem_addr_i;
   logic mem_wr_i;
   logic [7:0] mem_wdata_i;
   logic mem_rd_i;
   logic [7:0] mem_rdata_o;
   logic mem_rvalid_o;
   logic vfc_pulse_i;
   logic sense_discharge_i;
   logic sense_charge_i;
   logic self_dis_tick_i;
   logic [15:0] die_temperature_i;
   logic stat_o;
   logic stat_oe_o;
   logic sleep_allow_o;
   logic [2:0] wake_threshold_o;
   int errors;
   int cmp_count;
   logic [23:0] map_tab [15] = '{24'h00e53c, 24'h004530, 24'h014530, 24'h02e53c,
      24'h010000, 24'h011f00, 24'h020460, 24'h0030ff, 24'h0101ff, 24'h0102a8,
      24'h010304, 24'h010460, 24'h01054e, 24'h00dfff, 24'h010e00};

   gcm_host_model host_u (.clk_i(ref_clk_i), .addr_o(mem_addr_i), .wr_o(mem_wr_i),
      .wdata_o(mem_wdata_i), .rd_o(mem_rd_i), .rdata_i(mem_rdata_o),
      .rvalid_i(mem_rvalid_o));

   gcm_regs #(.FAST_CYCLES(64'd10), .SLOW_CYCLES(64'd40)) dut_u (.ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i), .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i),
      .mem_wdata_i(mem_wdata_i), .mem_rd_i(mem_rd_i), .mem_rdata_o(mem_rdata_o),
      .mem_rvalid_o(mem_rvalid_o), .vfc_pulse_i(vfc_pulse_i),
      .sense_discharge_i(sense_discharge_i), .sense_charge_i(sense_charge_i),
      .self_dis_tick_i(self_dis_tick_i), .die_temperature_i(die_temperature_i),
      .stat_o(stat_o), .stat_oe_o(stat_oe_o), .sleep_allow_o(sleep_allow_o),
      .wake_threshold_o(wake_threshold_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host_u.rd(a, d, ok);
      if (ok !== 1'b1) begin
         errors++;
         $display("Error read answer at %h expected 1 seen 0", a);
         stop_test();
      end else begin
         check($sformatf("read %h", a), {8'h00, d}, {8'h00, exp});
      end
   endtask

   // Counter events held high for n cycles
   task automatic bump(input int k, input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         vfc_pulse_i <= (k != 2);
         self_dis_tick_i <= (k == 2);
      end
      @(posedge ref_clk_i);
      vfc_pulse_i <= 1'b0;
      self_dis_tick_i <= 1'b0;
   endtask

   initial begin
      errors = 0;
      cmp_count = 0;
      rstn_i = 1'b0;
      vfc_pulse_i = 1'b0;
      sense_discharge_i = 1'b0;
      sense_charge_i = 1'b0;
      self_dis_tick_i = 1'b0;
      die_temperature_i = 16'h04a8;
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check("stat_oe", {15'h0000, stat_oe_o}, 16'h0000);
      check("stat", {15'h0000, stat_o}, 16'h0000);
      check("sleep_allow", {15'h0000, sleep_allow_o}, 16'h0001);
      check("wake_threshold", {13'h0000, wake_threshold_o}, 16'h0007);
      $display("Test reset done");

      host_u.wr(16'h00e5, 8'h3c);
      host_u.wr(16'h0045, 8'hf0);
      host_u.wr(16'h0045, 8'h3f);
      host_u.wr(gcm_pkg::ADDR_RESERVED, 8'h55);
      host_u.wr(16'h010e, 8'h77);
      host_u.wr(16'h0130, 8'h00);
      for (int i = 0; i < 15; i++) begin
         rd_chk(map_tab[i][23:8], map_tab[i][7:0]);
      end
      $display("Test map done");

      for (int k = 0; k < 3; k++) begin
         sense_discharge_i <= (k == 0);
         sense_charge_i <= (k == 1);
         bump(k, 3 + k);
         rd_chk(16'h010e - 16'(2 * k), 8'(3 + k));
         rd_chk(16'h010f - 16'(2 * k), 8'h00);
         host_u.clr_pair(k);
         if (k == 1) begin
            rd_chk(gcm_pkg::ADDR_CLEAR_CTRL, 8'h60);
         end
         rd_chk(16'h010e - 16'(2 * k), 8'h00);
         rd_chk(16'h010f - 16'(2 * k), 8'h00);
         rd_chk(gcm_pkg::ADDR_CLEAR_CTRL, 8'h60);
      end
      $display("Test counts done");

      sense_discharge_i <= 1'b1;
      sense_charge_i <= 1'b0;
      bump(0, 65538);
      rd_chk(gcm_pkg::ADDR_DIS_COUNT_LOW, 8'h02);
      rd_chk(gcm_pkg::ADDR_DIS_COUNT_HIGH, 8'h00);
      host_u.clr_pair(gcm_pkg::CLR_DIS_COUNT);
      rd_chk(gcm_pkg::ADDR_DIS_COUNT_HIGH, 8'h00);
      rd_chk(gcm_pkg::ADDR_DIS_COUNT_LOW, 8'h00);
      $display("Test wrap done");

      for (int t = 0; t < 2; t++) begin
         sense_discharge_i <= 1'b0;
         sense_charge_i <= 1'b0;
         host_u.clr_pair(3 + t);
         @(posedge ref_clk_i);
         sense_discharge_i <= (t == 0);
         sense_charge_i <= (t == 1);
         repeat (35) @(posedge ref_clk_i);
         sense_discharge_i <= 1'b0;
         sense_charge_i <= 1'b0;
         host_u.wr(16'h0108 - 16'(2 * t), 8'h55);
         rd_chk(16'h0108 - 16'(2 * t), 8'h03);
         rd_chk(16'h0109 - 16'(2 * t), 8'h00);
         rd_chk(gcm_pkg::ADDR_SLEEP_WAKE, 8'h4e);
      end
      $display("Test timers done");

      host_u.wr(gcm_pkg::ADDR_CLEAR_CTRL, 8'h40);
      rd_chk(gcm_pkg::ADDR_CLEAR_CTRL, 8'h40);
      check("stat_oe", {15'h0000, stat_oe_o}, 16'h0001);
      host_u.wr(gcm_pkg::ADDR_CLEAR_CTRL, 8'h20);
      rd_chk(gcm_pkg::ADDR_CLEAR_CTRL, 8'h20);
      check("stat_oe", {15'h0000, stat_oe_o}, 16'h0000);
      host_u.wr(gcm_pkg::ADDR_SLEEP_WAKE, 8'h04);
      rd_chk(gcm_pkg::ADDR_SLEEP_WAKE, 8'h04);
      check("sleep_allow", {15'h0000, sleep_allow_o}, 16'h0000);
      check("wake_threshold", {13'h0000, wake_threshold_o}, 16'h0002);
      $display("Test status pin done");
      stop_test();
   end
endmodule

bind gcm_regs gcm_chk chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
   .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_wdata_i(mem_wdata_i),
   .mem_rd_i(mem_rd_i), .mem_rdata_o(mem_rdata_o), .mem_rvalid_o(mem_rvalid_o),
   .vfc_pulse_i(vfc_pulse_i), .stat_o(stat_o), .stat_oe_o(stat_oe_o));

// [tb/gcm_chk.sv]
module gcm_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Host memory command port
   input wire logic [15:0] mem_addr_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic mem_rd_i,
   input wire logic [7:0] mem_rdata_o,
   input wire logic mem_rvalid_o,
   // Events and pins
   input wire logic vfc_pulse_i,
   input wire logic stat_o,
   input wire logic stat_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_rd(a);
      mem_rd_i && mem_addr_i == a;
   endsequence
   sequence s_clr_wr;
      mem_wr_i && mem_addr_i == gcm_pkg::ADDR_CLEAR_CTRL;
   endsequence
   sequence s_dis_clr(a);
      s_clr_wr ##0 mem_wdata_i[gcm_pkg::CLR_DIS_COUNT] ##1 !vfc_pulse_i
         ##1 !vfc_pulse_i ##1 (mem_rd_i && mem_addr_i == a);
   endsequence

   property p_read_lat;
      mem_rd_i |-> ##2 mem_rvalid_o;
   endproperty
   property p_rvalid_cause;
      mem_rvalid_o |-> $past(mem_rd_i, 2);
   endproperty
   property p_reserved_zero;
      s_rd(gcm_pkg::ADDR_RESERVED) |-> ##2 mem_rdata_o == 8'h00;
   endproperty
   property p_top_zero;
      mem_rd_i && mem_addr_i >= 16'h0110 && mem_addr_i <= gcm_pkg::ADDR_TOP
         |-> ##2 mem_rdata_o == 8'h00;
   endproperty
   property p_dis_clr(a);
      s_dis_clr(a) |-> ##2 mem_rdata_o == 8'h00;
   endproperty
   property p_clr_drop;
      (s_clr_wr ##0 (mem_wdata_i & gcm_pkg::CLR_CMD_MASK) != 8'h00)
         ##3 s_rd(gcm_pkg::ADDR_CLEAR_CTRL)
         |-> ##2 (mem_rdata_o & gcm_pkg::CLR_CMD_MASK) == 8'h00;
   endproperty
   property p_stat_level;
      logic b;
      (s_clr_wr, b = mem_wdata_i[gcm_pkg::CLR_STAT_LEVEL]) |-> ##3 stat_oe_o == !b;
   endproperty
   property p_stat_drive;
      stat_oe_o |-> stat_o == 1'b0;
   endproperty

   a_read_lat: assert property (p_read_lat)
      else $error("read answer not two cycles after request");
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("read answer without request");
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved location not zero");
   a_top_zero: assert property (p_top_zero)
      else $error("undecoded top location not zero");
   a_dis_clr_low: assert property (p_dis_clr(gcm_pkg::ADDR_DIS_COUNT_LOW))
      else $error("discharge count low byte not cleared");
   a_dis_clr_high: assert property (p_dis_clr(gcm_pkg::ADDR_DIS_COUNT_HIGH))
      else $error("discharge count high byte not cleared");
   a_clr_drop: assert property (p_clr_drop)
      else $error("clear bit did not drop");
   a_stat_level: assert property (p_stat_level)
      else $error("status pin enable does not follow level bit");
   a_stat_drive: assert property (p_stat_drive)
      else $error("status pin driven high");
endmodule

// [tb/gcm_host_model.sv]
module gcm_host_model (
   // Clock
   input wire logic clk_i,
   // Memory command port
   output logic [15:0] addr_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      addr_o = 16'h0000;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end

   // Released lines show the inverse of the last value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      if (a >= gcm_pkg::ADDR_ALIAS_BASE) begin
         return;
      end
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
      d = 8'hxx;
      ok = 1'b0;
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk_i);
         if (rvalid_i === 1'b1) begin
            d = rdata_i;
            ok = 1'b1;
         end
      end
   endtask

   task automatic clr_pair(input int b);
      wr(gcm_pkg::ADDR_CLEAR_CTRL, 8'h60 | (8'h01 << b));
      // Pair clears one edge after the bit lands
      @(posedge clk_i);
   endtask
endmodule
